// *** shared/rtcc_consts.svh ***
// rtcc offsets, field positions, limits and reset values
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH
`define RTCC_XTAL_HZ 32768
`define RTCC_SLAVE 7'h6F
`define RTCC_LAST_ADDR 8'h3F
`define RTCC_A1_BASE 6'h08
`define RTCC_CT_BASE 6'h10
`define RTCC_CT_END 6'h13
`define RTCC_TM_BASE 6'h30
`define RTCC_TM_END 6'h37
`define RTCC_ST_ADDR 6'h3F
`define RTCC_SEC_LEN 4'h8
`define RTCC_CT_LEN 4'h4
`define RTCC_ONE_LEN 4'h1
`define RTCC_BUF_LEN 8
`define RTCC_I_SEC 3'h0
`define RTCC_I_MIN 3'h1
`define RTCC_I_HR 3'h2
`define RTCC_I_DT 3'h3
`define RTCC_I_MO 3'h4
`define RTCC_I_YR 3'h5
`define RTCC_I_DW 3'h6
`define RTCC_I_Y2K 3'h7
`define RTCC_HR_MIL 7
`define RTCC_HR_PM 5
`define RTCC_EN_BIT 7
`define RTCC_ST_RTCF 0
`define RTCC_ST_WEL 1
`define RTCC_ST_REGISTER_WRITE_ENABLE_LATCH 2
`define RTCC_HR_MASK 8'h3F
`define RTCC_VAL_MASK 8'h7F
`define RTCC_MAX_SM 8'h59
`define RTCC_MAX_H24 6'h23
`define RTCC_MAX_H12 8'h12
`define RTCC_PRE_H12 8'h11
`define RTCC_MAX_MO 8'h12
`define RTCC_MAX_YR 8'h99
`define RTCC_MAX_DW 8'h06
`define RTCC_FIRST 8'h01
`define RTCC_Y2K_RST 8'h20
`define RTCC_AV_STATUS 4'h0
`define RTCC_AV_CTRL 4'h4
`define RTCC_AV_TLO 4'h8
`define RTCC_AV_THI 4'hC
`endif

// *** shared/rtcc_pkg.sv ***
// rtcc types: link states and the block's state record
package rtcc_pkg;
	typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WR, S_RD} rtcc_st_e;
	typedef struct packed {
		logic [2:0] scl_q;
		logic [2:0] sda_q;
		logic [2:0] xt_q;
		logic [15:0] pre;
		logic tick_d;
		rtcc_st_e st;
		logic [3:0] cnt;
		logic ackph;
		logic mack;
		logic [7:0] sh;
		logic [5:0] ptr;
		logic [5:0] base;
		logic [3:0] size;
		logic [2:0] idx;
		logic [7:0][7:0] bufr;
		logic [7:0] wmask;
		logic [19:0][7:0] nv;
		logic [7:0][7:0] tm;
		logic [7:0][7:0] pend;
		logic [7:0] pmask;
		logic pend_v;
		logic rtcf;
		logic write_enable_latch;
		logic register_write_enable_latch;
		logic al0;
		logic al1;
		logic oe_n;
		logic sda;
		logic link_en;
		logic waitreq;
		logic [31:0] rdata;
	} rtcc_state_s;
endpackage

// *** core/rtcc_core.sv ***
// rtc calendar with two-wire clock/control space and avalon status port
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`include "rtcc_consts.svh"
module rtcc_core #(
	parameter int TICKS_PER_SEC = `RTCC_XTAL_HZ
) (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// two-wire link
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// crystal timebase
	input wire logic xtal_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import rtcc_pkg::*;

	localparam logic [15:0] PRE_LAST = 16'(TICKS_PER_SEC - 1);

	rtcc_state_s s;
	rtcc_state_s n;
	logic scl_r;
	logic scl_f;
	logic start;
	logic stop;
	logic xt_r;
	logic tick;
	logic ack_ok;

	// bcd increment of one byte
	function automatic logic [7:0] bcd_inc(logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction

	// days in month, february from the leap test
	function automatic logic [7:0] dim(logic [7:0] mo, logic [7:0] yr);
		logic [1:0] m4;
		m4 = {yr[4], 1'b0} + yr[1:0];
		unique case (mo)
			8'h02: return (m4 == 2'h0) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// one second of calendar advance
	function automatic logic [7:0][7:0] tm_adv(logic [7:0][7:0] t);
		logic [7:0][7:0] r;
		logic c;
		logic pm;
		logic [7:0] h;
		r = t;
		c = 1'b0;
		pm = t[`RTCC_I_HR][`RTCC_HR_PM];
		h = {3'h0, t[`RTCC_I_HR][4:0]};
		if (t[`RTCC_I_SEC] == `RTCC_MAX_SM)
		begin
			r[`RTCC_I_SEC] = 8'h00;
			c = 1'b1;
		end
		else
			r[`RTCC_I_SEC] = bcd_inc(t[`RTCC_I_SEC]);
		if (c)
		begin
			if (t[`RTCC_I_MIN] == `RTCC_MAX_SM)
				r[`RTCC_I_MIN] = 8'h00;
			else
			begin
				r[`RTCC_I_MIN] = bcd_inc(t[`RTCC_I_MIN]);
				c = 1'b0;
			end
		end
		if (c)
		begin
			c = 1'b0;
			if (t[`RTCC_I_HR][`RTCC_HR_MIL])
			begin
				h = bcd_inc({2'h0, t[`RTCC_I_HR][5:0]});
				if (t[`RTCC_I_HR][5:0] == `RTCC_MAX_H24)
				begin
					h = 8'h00;
					c = 1'b1;
				end
				r[`RTCC_I_HR] = {t[`RTCC_I_HR][7:6], h[5:0]};
			end
			else
			begin
				if (h == `RTCC_MAX_H12)
					h = `RTCC_FIRST;
				else if (h == `RTCC_PRE_H12)
				begin
					h = `RTCC_MAX_H12;
					c = pm;
					pm = ~pm;
				end
				else
					h = bcd_inc(h);
				r[`RTCC_I_HR] = {t[`RTCC_I_HR][7:6], pm, h[4:0]};
			end
		end
		if (c)
		begin
			r[`RTCC_I_DW] = (t[`RTCC_I_DW] == `RTCC_MAX_DW) ? 8'h00 : t[`RTCC_I_DW] + 8'h01;
			if (t[`RTCC_I_DT] == dim(t[`RTCC_I_MO], t[`RTCC_I_YR]))
				r[`RTCC_I_DT] = `RTCC_FIRST;
			else
			begin
				r[`RTCC_I_DT] = bcd_inc(t[`RTCC_I_DT]);
				c = 1'b0;
			end
		end
		if (c)
		begin
			if (t[`RTCC_I_MO] == `RTCC_MAX_MO)
				r[`RTCC_I_MO] = `RTCC_FIRST;
			else
			begin
				r[`RTCC_I_MO] = bcd_inc(t[`RTCC_I_MO]);
				c = 1'b0;
			end
		end
		if (c)
		begin
			if (t[`RTCC_I_YR] == `RTCC_MAX_YR)
			begin
				r[`RTCC_I_YR] = 8'h00;
				r[`RTCC_I_Y2K] = bcd_inc(t[`RTCC_I_Y2K]);
			end
			else
				r[`RTCC_I_YR] = bcd_inc(t[`RTCC_I_YR]);
		end
		return r;
	endfunction

	// alarm section compare against live time
	function automatic logic al_hit(logic [19:0][7:0] nv, logic [7:0][7:0] t, int b);
		logic any;
		logic ok;
		logic [7:0] m;
		any = 1'b0;
		ok = 1'b1;
		for (int j = 0; j < 7; j++)
		begin
			m = (j == `RTCC_I_HR) ? `RTCC_HR_MASK : `RTCC_VAL_MASK;
			if (j != `RTCC_I_YR && nv[b + j][`RTCC_EN_BIT])
			begin
				any = 1'b1;
				if ((nv[b + j] & m) != (t[j] & m))
					ok = 1'b0;
			end
		end
		return any & ok;
	endfunction

	// first address of the section holding a
	function automatic logic [5:0] sec_base(logic [5:0] a);
		if (a < `RTCC_A1_BASE)
			return 6'h00;
		if (a < `RTCC_CT_BASE)
			return `RTCC_A1_BASE;
		if (a <= `RTCC_CT_END)
			return `RTCC_CT_BASE;
		if (a >= `RTCC_TM_BASE && a <= `RTCC_TM_END)
			return `RTCC_TM_BASE;
		return a;
	endfunction

	// length of the section holding a
	function automatic logic [3:0] sec_size(logic [5:0] a);
		if (a < `RTCC_CT_BASE || (a >= `RTCC_TM_BASE && a <= `RTCC_TM_END))
			return `RTCC_SEC_LEN;
		if (a <= `RTCC_CT_END)
			return `RTCC_CT_LEN;
		return `RTCC_ONE_LEN;
	endfunction

	// live byte of the clock/control space, undefined reads zero
	function automatic logic [7:0] ccr_byte(rtcc_state_s q, logic [5:0] a);
		if (a <= `RTCC_CT_END)
			return q.nv[a[4:0]];
		if (a >= `RTCC_TM_BASE && a <= `RTCC_TM_END)
			return q.tm[a[2:0]];
		if (a == `RTCC_ST_ADDR)
			return {1'b0, q.al1, q.al0, 2'b00, q.register_write_enable_latch, q.write_enable_latch, q.rtcf};
		return 8'h00;
	endfunction

	// fill the buffer with the section of a
	function automatic rtcc_state_s load(rtcc_state_s q, rtcc_state_s o, logic [5:0] a);
		o.base = sec_base(a);
		o.size = sec_size(a);
		o.idx = 3'(a - o.base);
		o.wmask = 8'h00;
		for (int i = 0; i < `RTCC_BUF_LEN; i++)
			o.bufr[i] = (i < int'(o.size)) ? ccr_byte(q, 6'(o.base + 6'(i))) : 8'h00;
		return o;
	endfunction

	// synchronised edges and conditions
	assign scl_r = s.scl_q[1] & ~s.scl_q[2];
	assign scl_f = ~s.scl_q[1] & s.scl_q[2];
	assign start = s.scl_q[1] & s.scl_q[2] & s.sda_q[2] & ~s.sda_q[1];
	assign stop = s.scl_q[1] & s.scl_q[2] & ~s.sda_q[2] & s.sda_q[1];
	assign xt_r = s.xt_q[1] & ~s.xt_q[2];
	assign tick = xt_r && s.pre == PRE_LAST;

	// acknowledge decision for the byte just received
	always_comb
	begin
		unique case (s.st)
			S_DEV: ack_ok = s.sh[7:1] == `RTCC_SLAVE;
			S_AHI: ack_ok = s.sh == 8'h00;
			S_ALO: ack_ok = s.sh <= `RTCC_LAST_ADDR;
			S_WR: ack_ok = !(s.size == `RTCC_ONE_LEN && s.wmask != 8'h00);
			default: ack_ok = 1'b0;
		endcase
	end

	// next state of the whole block
	always_comb
	begin
		logic [7:0][7:0] adv;
		adv = s.tm;
		n = s;
		n.scl_q = {s.scl_q[1:0], scl_i};
		n.sda_q = {s.sda_q[1:0], sda_i};
		n.xt_q = {s.xt_q[1:0], xtal_i};
		n.tick_d = tick;
		// prescaler and counters keep running whatever the link does
		if (xt_r)
			n.pre = (s.pre == PRE_LAST) ? 16'h0000 : s.pre + 16'h0001;
		if (tick)
		begin
			if (!s.rtcf)
				adv = tm_adv(s.tm);
			for (int i = 0; i < `RTCC_BUF_LEN; i++)
				if (s.pend_v && s.pmask[i])
					adv[i] = s.pend[i];
			if (s.pend_v)
				n.rtcf = 1'b0;
			n.pend_v = 1'b0;
			n.tm = adv;
		end
		// two-wire slave
		if (start && s.link_en)
		begin
			n.st = S_DEV;
			n.cnt = 4'h0;
			n.ackph = 1'b0;
			n.oe_n = 1'b1;
		end
		else if (stop)
		begin
			// the stop's own clock rise is counted as one started bit
			if (s.st == S_WR && s.cnt == 4'h1 && !s.ackph && s.wmask != 8'h00)
			begin
				if (s.base == `RTCC_ST_ADDR)
				begin
					n.write_enable_latch = s.bufr[0][`RTCC_ST_WEL];
					n.register_write_enable_latch = s.bufr[0][`RTCC_ST_WEL] & s.write_enable_latch & s.bufr[0][`RTCC_ST_REGISTER_WRITE_ENABLE_LATCH];
				end
				else if (s.register_write_enable_latch && s.base == `RTCC_TM_BASE)
				begin
					n.pend = s.bufr;
					n.pmask = s.wmask;
					n.pend_v = 1'b1;
				end
				else if (s.register_write_enable_latch && s.base <= `RTCC_CT_BASE)
					for (int i = 0; i < `RTCC_BUF_LEN; i++)
						if (s.wmask[i])
							n.nv[s.base[4:0] + 5'(i)] = s.bufr[i];
			end
			n.st = S_IDLE;
			n.ackph = 1'b0;
			n.oe_n = 1'b1;
		end
		else if (s.st == S_RD)
		begin
			if (scl_r && s.ackph)
				n.mack = s.sda_q[1];
			else if (scl_r)
				n.cnt = s.cnt + 4'h1;
			if (scl_f && s.ackph)
			begin
				n.ackph = 1'b0;
				n.cnt = 4'h0;
				if (!s.mack && s.size != `RTCC_ONE_LEN)
					n.oe_n = s.bufr[s.idx][7];
				else
				begin
					n.st = S_IDLE;
					n.oe_n = 1'b1;
				end
			end
			else if (scl_f && s.cnt == 4'h8)
			begin
				n.oe_n = 1'b1;
				n.ackph = 1'b1;
				n.ptr = 6'(s.base + 6'(s.idx) + 6'h01);
				n.idx = (4'(s.idx) + 4'h1 == s.size) ? 3'h0 : s.idx + 3'h1;
			end
			else if (scl_f)
				n.oe_n = s.bufr[s.idx][3'h7 - s.cnt[2:0]];
		end
		else if (s.st != S_IDLE)
		begin
			if (scl_r && !s.ackph)
			begin
				n.sh = {s.sh[6:0], s.sda_q[1]};
				n.cnt = s.cnt + 4'h1;
			end
			if (scl_f && !s.ackph && s.cnt == 4'h8)
			begin
				n.ackph = 1'b1;
				n.oe_n = ~ack_ok;
			end
			else if (scl_f && s.ackph)
			begin
				n.ackph = 1'b0;
				n.cnt = 4'h0;
				n.oe_n = 1'b1;
				if (s.oe_n)
					n.st = S_IDLE;
				else
				begin
					unique case (s.st)
						S_DEV:
						begin
							n.st = s.sh[0] ? S_RD : S_AHI;
							if (s.sh[0])
							begin
								n = load(s, n, s.ptr);
								n.oe_n = n.bufr[n.idx][7];
								if (n.base == `RTCC_ST_ADDR)
								begin
									n.al0 = 1'b0;
									n.al1 = 1'b0;
								end
							end
						end
						S_AHI: n.st = S_ALO;
						S_ALO:
						begin
							n.st = S_WR;
							n.ptr = s.sh[5:0];
							n = load(s, n, s.sh[5:0]);
						end
						default:
						begin
							n.bufr[s.idx] = s.sh;
							n.wmask[s.idx] = 1'b1;
							n.ptr = 6'(s.base + 6'(s.idx) + 6'h01);
							n.idx = (4'(s.idx) + 4'h1 == s.size) ? 3'h0 : s.idx + 3'h1;
						end
					endcase
				end
			end
		end
		// alarm flags, set after a clear in the same cycle
		if (s.tick_d && al_hit(s.nv, s.tm, 0))
			n.al0 = 1'b1;
		if (s.tick_d && al_hit(s.nv, s.tm, int'(`RTCC_A1_BASE)))
			n.al1 = 1'b1;
		// avalon slave: one wait cycle, then answer
		n.waitreq = 1'b1;
		if ((avs_read_i || avs_write_i) && s.waitreq)
		begin
			n.waitreq = 1'b0;
			unique case (avs_address_i)
				`RTCC_AV_STATUS: n.rdata = {25'h0, s.st != S_IDLE, s.pend_v, s.al1, s.al0,
					s.register_write_enable_latch, s.write_enable_latch, s.rtcf};
				`RTCC_AV_CTRL: n.rdata = {31'h0, s.link_en};
				`RTCC_AV_TLO: n.rdata = s.tm[3:0];
				`RTCC_AV_THI: n.rdata = s.tm[7:4];
				default: n.rdata = 32'h0;
			endcase
		end
		if (avs_write_i && !s.waitreq && avs_address_i == `RTCC_AV_CTRL && avs_byteenable_i[0])
			n.link_en = avs_writedata_i[0];
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.scl_q <= 3'h7;
			s.sda_q <= 3'h7;
			s.tm[`RTCC_I_Y2K] <= `RTCC_Y2K_RST;
			s.nv[`RTCC_A1_BASE - 6'h01] <= `RTCC_Y2K_RST;
			s.nv[`RTCC_CT_BASE - 6'h01] <= `RTCC_Y2K_RST;
			s.rtcf <= 1'b1;
			s.oe_n <= 1'b1;
			s.link_en <= 1'b1;
			s.waitreq <= 1'b1;
		end
		else
			s <= n;
	end

	// outputs straight from the state register
	assign sda_o = s.sda;
	assign sda_oe_n_o = s.oe_n;
	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = s.waitreq;

	// checks
	AST_TM_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(s.tm) |-> $past(tick)) else $error("time changed off tick");
	AST_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
		s.rtcf && !s.pend_v |=> $stable(s.tm)) else $error("halted clock moved");
	AST_SEC_ROLL: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && !s.rtcf && !s.pend_v && s.tm[`RTCC_I_SEC] == `RTCC_MAX_SM
		|=> s.tm[`RTCC_I_SEC] == 8'h00 && $changed(s.tm[`RTCC_I_MIN]))
		else $error("seconds rollover wrong");
	AST_PEND_REGISTER_WRITE_ENABLE_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(s.pend_v) |-> $past(s.register_write_enable_latch)) else $error("time staged without enable");
	AST_PEND_APPLY: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && !stop && s.pend_v && s.pmask[`RTCC_I_SEC]
		|=> !s.pend_v && s.tm[`RTCC_I_SEC] == $past(s.pend[`RTCC_I_SEC]))
		else $error("staged seconds not loaded on tick");
	AST_ACK_SLAVE: assert property (@(posedge clk_i) disable iff (rst_i)
		s.st == S_DEV && s.ackph && !s.oe_n |-> s.sh[7:1] == `RTCC_SLAVE)
		else $error("acked foreign slave byte");
	AST_STATUS_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		s.st == S_RD && s.ackph && scl_f && s.size == `RTCC_ONE_LEN |=> s.st == S_IDLE)
		else $error("status read continued");
	AST_PTR_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
		s.st == S_RD && !s.ackph && scl_f && s.cnt == 4'h8
		|=> s.ptr == 6'($past(s.base) + 6'($past(s.idx)) + 6'h01))
		else $error("pointer not last plus one");
	AST_SNAP: assert property (@(posedge clk_i) disable iff (rst_i)
		s.st == S_DEV && s.ackph && scl_f && !s.oe_n && s.sh[0]
		|=> s.base != `RTCC_TM_BASE || s.bufr == $past(s.tm))
		else $error("read snapshot differs from time");
endmodule // rtcc_core

// *** testbench/rtcc_host.sv ***
// two-wire bus master model that drives the clock/control space
module rtcc_host #(
	parameter int HALF = 12
) (
	// system
	input wire logic clk_i,
	// data line level as seen on the wire
	input wire logic sda_i,
	// pin drive: clock level and a pull-low on data
	output logic scl_o,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// bus idle: clock high, data released to the pull-up
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// one half phase of the serial clock
	task automatic wt();
		repeat (HALF) @(posedge clk_i);
	endtask
	// start or repeated start: data falls while clock is high
	task automatic start();
		sda_low_o <= 1'b0;
		wt();
		scl_o <= 1'b1;
		wt();
		sda_low_o <= 1'b1;
		wt();
		scl_o <= 1'b0;
		wt();
	endtask
	// stop: data rises while clock is high
	task automatic stop();
		sda_low_o <= 1'b1;
		wt();
		scl_o <= 1'b1;
		wt();
		sda_low_o <= 1'b0;
		wt();
	endtask
	// one bit: data moves only while clock is low, sampled late in the high phase
	task automatic bitx(input logic b, output logic s);
		sda_low_o <= !b;
		wt();
		scl_o <= 1'b1;
		wt();
		s = sda_i;
		scl_o <= 1'b0;
		wt();
	endtask
	// one byte msb first, then the ninth bit a (released to read an ack when a is 1, pulled low as master ack when 0)
	task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic ak);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(a, ak);
	endtask
endmodule // rtcc_host

// *** testbench/rtcc_core_bench.sv ***
// self-checking bench: avalon status port and two-wire clock/control access
`include "rtcc_consts.svh"
module rtcc_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TPS = 4;
	localparam logic [3:0] A_ST = `RTCC_AV_STATUS;
	localparam logic [3:0] A_CT = `RTCC_AV_CTRL;
	localparam logic [3:0] A_LO = `RTCC_AV_TLO;
	localparam logic [3:0] A_HI = `RTCC_AV_THI;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic xtal = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdat;
	logic waitr, sda_o, oe_n, scl, sda_low, sda_w, ak;
	logic [7:0] q;
	logic [31:0] r;
	logic [7:0] tw [8] = '{8'h58, 8'h59, 8'hA3, 8'h28, 8'h02, 8'h23, 8'h06, 8'h20};
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	// clock and wired-and data line with pull-up
	always #2 clk = ~clk;
	assign sda_w = !(sda_low || (!oe_n && !sda_o));
	rtcc_core #(.TICKS_PER_SEC(TPS)) u_rtcc_core (.clk_i(clk), .rst_i(rst), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(oe_n), .xtal_i(xtal),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(waitr));
	rtcc_host u_rtcc_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
	// compare and count
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// avalon access: hold the request until waitrequest is sampled low
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] o);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		// no latency assumed: waitrequest low ends this wait, the hang guard bounds it
		do
			@(posedge clk);
		while (waitr !== 1'b0);
		o = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		av(1'b0, a, 32'h0, r);
		chk("avalon read", r, e);
	endtask
	// one second: TPS crystal rising edges, then settle
	task automatic tick();
		repeat (TPS)
		begin
			xtal <= 1'b1;
			repeat (4) @(posedge clk);
			xtal <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask
	// link byte write with expected ack, read with master ack
	task automatic tx(input logic [7:0] d, input logic e);
		u_rtcc_host.xb(d, 1'b1, q, ak);
		chk("link ack", ak, e);
	endtask
	task automatic rx(input logic m, input logic [7:0] e);
		u_rtcc_host.xb(8'hFF, m, q, ak);
		chk("link data", q, e);
	endtask
	// start, write slave byte and two address bytes
	task automatic hdr(input logic [7:0] a);
		u_rtcc_host.start();
		tx(8'hDE, 1'b0);
		tx(8'h00, 1'b0);
		tx(a, 1'b0);
	endtask
	task automatic done(input string n);
		$display("test %s finished, mismatches so far %0d", n, fail_count);
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("sda release", oe_n, 1'b1);
		chk("sda level", sda_o, 1'b0);
		rdchk(A_ST, 32'h1);
		rdchk(A_HI, 32'h20000000);
		tick();
		rdchk(A_LO, 32'h0);
		rdchk(4'h2, 32'h0);
		done("reset");
		// link disabled: start ignored
		av(1'b1, A_CT, 32'h0, r);
		u_rtcc_host.start();
		tx(8'hDE, 1'b1);
		u_rtcc_host.stop();
		av(1'b1, A_CT, 32'h1, r);
		rdchk(A_CT, 32'h1);
		u_rtcc_host.start();
		tx(8'hA0, 1'b1);
		u_rtcc_host.stop();
		done("select");
		// two-step latch enable through the status byte
		hdr(8'h3F);
		tx(8'h02, 1'b0);
		u_rtcc_host.stop();
		hdr(8'h3F);
		tx(8'h06, 1'b0);
		u_rtcc_host.stop();
		rdchk(A_ST, 32'h7);
		hdr(8'h30);
		foreach (tw[i])
			tx(tw[i], 1'b0);
		u_rtcc_host.stop();
		rdchk(A_ST, 32'h27);
		tick();
		rdchk(A_LO, 32'h28A35958);
		rdchk(A_HI, 32'h20062302);
		rdchk(A_ST, 32'h6);
		tick();
		tick();
		rdchk(A_LO, 32'h01800000);
		rdchk(A_HI, 32'h20002303);
		done("time");
		// snapshot read wraps in the time section; pointer moves on
		tick();
		hdr(8'h37);
		u_rtcc_host.start();
		tx(8'hDF, 1'b0);
		rx(1'b0, 8'h20);
		tick();
		rx(1'b1, 8'h01);
		u_rtcc_host.stop();
		rdchk(A_LO, 32'h01800002);
		u_rtcc_host.start();
		tx(8'hDF, 1'b0);
		rx(1'b1, 8'h00);
		u_rtcc_host.stop();
		// an undefined location reads zero
		hdr(8'h20);
		u_rtcc_host.start();
		tx(8'hDF, 1'b0);
		rx(1'b1, 8'h00);
		u_rtcc_host.stop();
		done("read");
		// repeated start before stop abandons the staged time
		hdr(8'h30);
		tx(8'h45, 1'b0);
		u_rtcc_host.start();
		u_rtcc_host.stop();
		rdchk(A_ST, 32'h6);
		tick();
		rdchk(A_LO, 32'h01800003);
		hdr(8'h31);
		tx(8'h15, 1'b0);
		u_rtcc_host.stop();
		tick();
		rdchk(A_LO, 32'h01801504);
		done("write");
		// status byte takes one byte only
		hdr(8'h3F);
		tx(8'h00, 1'b0);
		tx(8'h00, 1'b1);
		u_rtcc_host.stop();
		rdchk(A_ST, 32'h6);
		hdr(8'h3F);
		tx(8'h00, 1'b0);
		u_rtcc_host.stop();
		rdchk(A_ST, 32'h0);
		hdr(8'h30);
		u_rtcc_host.xb(8'h11, 1'b1, q, ak);
		u_rtcc_host.stop();
		tick();
		rdchk(A_LO, 32'h01801505);
		done("protect");
		// alarm on live seconds while a time read holds its snapshot
		hdr(8'h3F);
		tx(8'h02, 1'b0);
		u_rtcc_host.stop();
		hdr(8'h3F);
		tx(8'h06, 1'b0);
		u_rtcc_host.stop();
		hdr(8'h00);
		tx(8'h86, 1'b0);
		u_rtcc_host.stop();
		hdr(8'h30);
		u_rtcc_host.start();
		tx(8'hDF, 1'b0);
		rx(1'b0, 8'h05);
		tick();
		rdchk(A_ST, 32'h4E);
		rx(1'b1, 8'h15);
		u_rtcc_host.stop();
		hdr(8'h3F);
		u_rtcc_host.start();
		tx(8'hDF, 1'b0);
		rx(1'b1, 8'h26);
		u_rtcc_host.stop();
		rdchk(A_ST, 32'h6);
		done("alarm");
		// reset in mid-run halts the clock again; 12-hour count past midnight
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rdchk(A_ST, 32'h1);
		tick();
		rdchk(A_LO, 32'h0);
		hdr(8'h3F);
		tx(8'h02, 1'b0);
		u_rtcc_host.stop();
		hdr(8'h3F);
		tx(8'h06, 1'b0);
		u_rtcc_host.stop();
		hdr(8'h30);
		tx(8'h59, 1'b0);
		tx(8'h59, 1'b0);
		tx(8'h31, 1'b0);
		u_rtcc_host.stop();
		tick();
		rdchk(A_LO, 32'h00315959);
		tick();
		rdchk(A_LO, 32'h01120000);
		rdchk(A_HI, 32'h20010000);
		done("format");
		end_of_test();
	end
endmodule // rtcc_core_bench
